// [hw/ccr_pkg.sv]
// Package for the clock generator control register bank, bytes 11 to 15
package ccr_pkg;
  localparam logic [7:0] ADDR_MGMT_STOP  = 8'h0B;
  localparam logic [7:0] ADDR_BLOCK_LEN  = 8'h0C;
  localparam logic [7:0] ADDR_DRIVE_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_MULT_LOW   = 8'h0E;
  localparam logic [7:0] ADDR_MULT_DIV   = 8'h0F;

  // Byte 11 field positions
  localparam int B11_PAIR2_SEL   = 3;
  localparam int B11_PAIR1_SEL   = 2;
  localparam int B11_GEN2        = 1;
  localparam int B11_STOP_QUAL   = 0;
  // Byte 13 field positions
  localparam int B13_USB_DRIVE   = 7;
  localparam int B13_BUS_DRIVE   = 6;
  localparam int B13_SPREAD      = 5;
  localparam int B13_STOR_SPREAD = 4;
  localparam int B13_STRAP_OVR   = 3;
  localparam int B13_SE_DRIVE    = 2;
  localparam int B13_RESERVED1   = 1;
  localparam int B13_SOFT_STOP   = 0;
  // Byte 15 field positions
  localparam int B15_MULT_MSB    = 7;

  // Reset values; byte 11 bit 1 is hardware status and not stored
  localparam logic [7:0] RST_MGMT_STOP  = 8'h05;
  localparam logic [7:0] RST_BLOCK_LEN  = 8'h0D;
  localparam logic [7:0] RST_DRIVE_CTRL = 8'hCF;
  localparam logic [7:0] RST_MULT_LOW   = 8'h00;
  localparam logic [7:0] RST_MULT_DIV   = 8'h00;
  localparam logic [7:0] MASK_BLOCK_LEN = 8'h3F;
  localparam logic [7:0] MASK_MGMT_STOP = 8'hFD;

  typedef struct packed {
    logic [7:0] mgmt_stop;
    logic [7:0] block_len;
    logic [7:0] drive_ctrl;
    logic [7:0] mult_low;
    logic [7:0] mult_div;
    logic [1:0] stop_sync;
    logic [1:0] gen2_sync;
    logic [1:0] strap_sync;
    logic [7:0] rd_data;
  } ccr_state_type;

  typedef struct packed {
    logic       en;
    logic       pair1;
    logic       pair2;
  } ccr_route_type;

  typedef struct packed {
    logic [8:0] mult;
    logic [6:0] div;
    logic [2:0] freq_sel;
    logic       active;
  } ccr_freq_type;
endpackage : ccr_pkg

// [hw/ccr_regs.sv]
// Control register bank bytes 11 to 15 of the clock generator
// How it works
// - Management clock enable routes M1 to pair 1, pair 2 (strap high) or both.
// - Byte 11 bit 1 is read-only, reflecting the gen2 compliance input.
// - Byte 11 bit 0 resets 1; when 1 pair 2 obeys the stop input.
// - Byte 13 bits 7, 6, 2 are mid drive bits, reset 1, 1 is higher.
// - Byte 13 bit 5 picks main PLL spread, 0 half percent, 1 one percent.
// - Byte 13 bit 4, reset 0, enables spread on the storage clock.
// - Byte 13 bit 3 default 1 lets strap set modes; 0 allows overwrite while latches are open.
// - Soft stop bit written 0 stops stoppable bus outputs cleanly.
// - Soft stop bit written 1 restarts stopped bus outputs cleanly.
// - Nine-bit multiplier and seven-bit divider reset zero, used when programmable.
// - Override clear uses latched strap ratio, set uses software select.
// - Programmable frequency is gear constant times multiplier over divider.
`timescale 1ns/1ps
module ccr_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output      logic [7:0]           reg_rdata,
  output      logic [5:0]           block_read_count,
  input  wire logic                 cpu_stop_pin_n,
  input  wire logic                 gen2_compliant_pin,
  input  wire logic                 debug_port_strap,
  input  wire logic                 mgmt_clock_enable,
  input  wire logic                 latches_open,
  input  wire logic                 prog_cpu_enable,
  input  wire logic                 freq_select_override,
  input  wire logic [2:0]           soft_freq_select,
  input  wire logic [2:0]           latched_freq_strap,
  output      ccr_pkg::ccr_route_type mgmt_route,
  output      logic                 pair2_stop,
  output      logic                 usb_drive_mid,
  output      logic                 bus_clock_drive_mid,
  output      logic                 single_ended_drive_mid,
  output      logic                 main_pll_spread_depth,
  output      logic                 storage_spread_enable,
  output      logic                 strap_overwrite_allowed,
  output      logic                 soft_bus_clock_stop,
  output      ccr_pkg::ccr_freq_type  cpu_freq
);
  ccr_pkg::ccr_state_type state;
  ccr_pkg::ccr_state_type next_state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  always_comb begin
    next_state = state;
    // Pins come from outside the clock domain
    next_state.stop_sync  = {state.stop_sync[0], ~cpu_stop_pin_n};
    next_state.gen2_sync  = {state.gen2_sync[0], gen2_compliant_pin};
    next_state.strap_sync = {state.strap_sync[0], debug_port_strap};
    if (reg_wr) begin
      if (hit(reg_addr, ccr_pkg::ADDR_MGMT_STOP)) begin
        next_state.mgmt_stop = reg_wdata & ccr_pkg::MASK_MGMT_STOP;
      end
      if (hit(reg_addr, ccr_pkg::ADDR_BLOCK_LEN)) begin
        next_state.block_len = reg_wdata & ccr_pkg::MASK_BLOCK_LEN;
      end
      if (hit(reg_addr, ccr_pkg::ADDR_DRIVE_CTRL)) begin
        next_state.drive_ctrl = reg_wdata;
      end
      if (hit(reg_addr, ccr_pkg::ADDR_MULT_LOW)) begin
        next_state.mult_low = reg_wdata;
      end
      if (hit(reg_addr, ccr_pkg::ADDR_MULT_DIV)) begin
        next_state.mult_div = reg_wdata;
      end
    end
    // Read data is registered; unmapped addresses return zero
    next_state.rd_data = state.rd_data;
    if (reg_rd) begin
      unique case (reg_addr)
        ccr_pkg::ADDR_MGMT_STOP: begin
          next_state.rd_data = state.mgmt_stop;
          next_state.rd_data[ccr_pkg::B11_GEN2] = state.gen2_sync[1];
        end
        ccr_pkg::ADDR_BLOCK_LEN:  next_state.rd_data = state.block_len;
        ccr_pkg::ADDR_DRIVE_CTRL: next_state.rd_data = state.drive_ctrl;
        ccr_pkg::ADDR_MULT_LOW:   next_state.rd_data = state.mult_low;
        ccr_pkg::ADDR_MULT_DIV:   next_state.rd_data = state.mult_div;
        default:                  next_state.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state.mgmt_stop  <= ccr_pkg::RST_MGMT_STOP;
      state.block_len  <= ccr_pkg::RST_BLOCK_LEN;
      state.drive_ctrl <= ccr_pkg::RST_DRIVE_CTRL;
      state.mult_low   <= ccr_pkg::RST_MULT_LOW;
      state.mult_div   <= ccr_pkg::RST_MULT_DIV;
      state.stop_sync  <= 2'h0;
      state.gen2_sync  <= 2'h0;
      state.strap_sync <= 2'h0;
      state.rd_data    <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata        = state.rd_data;
  assign block_read_count = state.block_len[5:0];

  // Both select bits clear is reserved: nothing is routed then
  always_comb begin
    mgmt_route.en    = mgmt_clock_enable;
    mgmt_route.pair1 = mgmt_clock_enable & state.mgmt_stop[ccr_pkg::B11_PAIR1_SEL];
    mgmt_route.pair2 = mgmt_clock_enable & state.mgmt_stop[ccr_pkg::B11_PAIR2_SEL]
                       & state.strap_sync[1];
  end

  assign pair2_stop = state.mgmt_stop[ccr_pkg::B11_STOP_QUAL] & state.stop_sync[1];

  assign usb_drive_mid          = state.drive_ctrl[ccr_pkg::B13_USB_DRIVE];
  assign bus_clock_drive_mid    = state.drive_ctrl[ccr_pkg::B13_BUS_DRIVE];
  assign single_ended_drive_mid = state.drive_ctrl[ccr_pkg::B13_SE_DRIVE];
  assign main_pll_spread_depth  = state.drive_ctrl[ccr_pkg::B13_SPREAD];
  assign storage_spread_enable  = state.drive_ctrl[ccr_pkg::B13_STOR_SPREAD];
  // Overwrite only while the strap latches are still open
  assign strap_overwrite_allowed = ~state.drive_ctrl[ccr_pkg::B13_STRAP_OVR] & latches_open;
  // Stop level is registered; output gating waits for a low clock phase downstream
  assign soft_bus_clock_stop = ~state.drive_ctrl[ccr_pkg::B13_SOFT_STOP];

  always_comb begin
    cpu_freq.active   = prog_cpu_enable;
    cpu_freq.mult     = {state.mult_div[ccr_pkg::B15_MULT_MSB], state.mult_low};
    cpu_freq.div      = state.mult_div[6:0];
    cpu_freq.freq_sel = freq_select_override ? soft_freq_select : latched_freq_strap;
  end
endmodule : ccr_regs

// [test/ccr_host.sv]
// Host model issuing register writes and reads
`timescale 1ns/1ps
module ccr_host (
  input  wire logic       clk,
  output      logic       reg_wr, reg_rd,
  output      logic [7:0] reg_addr, reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    {reg_wr, reg_wdata} <= {1'b0, ~d}; // Released data must not echo the last byte
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    #1 d = reg_rdata;
  endtask : rd
endmodule : ccr_host

// [test/ccr_regs_sva.sv]
// Checker for the register bank outputs
`timescale 1ns/1ps
module ccr_regs_sva (
  input wire logic clk, rst_n, reg_wr, reg_rd, gen2_compliant_pin, latches_open, pair2_stop,
  input wire logic main_pll_spread_depth, storage_spread_enable, strap_overwrite_allowed, soft_bus_clock_stop,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [5:0] block_read_count,
  input wire ccr_pkg::ccr_freq_type cpu_freq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [4:0] w = {5{reg_wr}} & {reg_addr == 8'h0F, reg_addr == 8'h0E, reg_addr == 8'h0D,
                                       reg_addr == 8'h0C, reg_addr == 8'h0B};
  property p_soft; w[2] |=> soft_bus_clock_stop == !$past(reg_wdata[0]); endproperty
  a_soft: assert property (p_soft) else $error("soft stop wrong");
  property p_spr; w[2] |=> main_pll_spread_depth == $past(reg_wdata[5]); endproperty
  a_spr: assert property (p_spr) else $error("spread depth wrong");
  property p_sata; w[2] |=> storage_spread_enable == $past(reg_wdata[4]); endproperty
  a_sata: assert property (p_sata) else $error("storage spread wrong");
  property p_ovr; w[2] |=> strap_overwrite_allowed == (!$past(reg_wdata[3]) && latches_open); endproperty
  a_ovr: assert property (p_ovr) else $error("strap overwrite wrong");
  property p_qual; w[0] && !reg_wdata[0] |=> !pair2_stop [*2]; endproperty
  a_qual: assert property (p_qual) else $error("pair 2 stopped while free running");
  property p_gen2; gen2_compliant_pin [*4] ##0 (reg_rd && reg_addr == 8'h0B) |=> reg_rdata[1]; endproperty
  a_gen2: assert property (p_gen2) else $error("gen2 flag wrong");
  property p_gen2_low; !gen2_compliant_pin [*4] ##0 (reg_rd && reg_addr == 8'h0B) |=> !reg_rdata[1]; endproperty
  a_gen2_low: assert property (p_gen2_low) else $error("gen2 flag set for a non compliant part");
  property p_cnt; w[1] |=> block_read_count == $past(reg_wdata[5:0]); endproperty
  a_cnt: assert property (p_cnt) else $error("byte count wrong");
  property p_n; w[3] |=> cpu_freq.mult[7:0] == $past(reg_wdata); endproperty
  a_n: assert property (p_n) else $error("multiplier low wrong");
  property p_m; w[4] |=> cpu_freq.div == $past(reg_wdata[6:0]) && cpu_freq.mult[8] == $past(reg_wdata[7]); endproperty
  a_m: assert property (p_m) else $error("divider wrong");
  cover property (w[2] ##1 soft_bus_clock_stop);
  cover property (w[4]);
  cover property (pair2_stop);
endmodule : ccr_regs_sva
bind ccr_regs ccr_regs_sva u_sva (.clk, .rst_n, .reg_wr, .reg_rd, .gen2_compliant_pin, .latches_open, .pair2_stop,
  .main_pll_spread_depth, .storage_spread_enable, .strap_overwrite_allowed, .soft_bus_clock_stop, .reg_addr,
  .reg_wdata, .reg_rdata, .block_read_count, .cpu_freq);

// [test/ccr_regs_tb.sv]
// Testbench for the register bank
`timescale 1ns/1ps
module ccr_regs_tb;
  logic clk, rst_n, reg_wr, reg_rd, cpu_stop_pin_n, gen2_compliant_pin, debug_port_strap, mgmt_clock_enable;
  logic latches_open, prog_cpu_enable, freq_select_override, pair2_stop, usb_drive_mid, bus_clock_drive_mid;
  logic single_ended_drive_mid, main_pll_spread_depth, storage_spread_enable, strap_overwrite_allowed;
  logic soft_bus_clock_stop;
  logic [2:0] soft_freq_select, latched_freq_strap;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] block_read_count;
  ccr_pkg::ccr_route_type mgmt_route;
  ccr_pkg::ccr_freq_type  cpu_freq;
  int n_fail = 0;
  int checked = 0;
  ccr_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  ccr_regs DUT (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .block_read_count, .cpu_stop_pin_n,
    .gen2_compliant_pin, .debug_port_strap, .mgmt_clock_enable, .latches_open, .prog_cpu_enable,
    .freq_select_override, .soft_freq_select, .latched_freq_strap, .mgmt_route, .pair2_stop, .usb_drive_mid,
    .bus_clock_drive_mid, .single_ended_drive_mid, .main_pll_spread_depth, .storage_spread_enable,
    .strap_overwrite_allowed, .soft_bus_clock_stop, .cpu_freq);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, e);
    host.rd(a, d);
    chk("rdata", e, d);
  endtask : rdc
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #200000 n_fail++;
    stop_test;
  end
  initial begin
    {rst_n, cpu_stop_pin_n, gen2_compliant_pin, debug_port_strap, mgmt_clock_enable} = 5'b01111;
    {latches_open, prog_cpu_enable, freq_select_override, soft_freq_select, latched_freq_strap} = 9'b111101010;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rdc(8'h0B, 8'h07);
    rdc(8'h0C, 8'h0D);
    rdc(8'h0D, 8'hCF);
    rdc(8'h0E, 8'h00);
    rdc(8'h0F, 8'h00);
    rdc(8'h10, 8'h00);
    chk("count", 6'h0D, block_read_count);
    host.wr(8'h0C, 8'hFF);
    rdc(8'h0C, 8'h3F);
    chk("count", 6'h3F, block_read_count);
    $display("reset and count test done");
    for (int i = 1; i < 4; i++) begin
      host.wr(8'h0B, {4'h0, 2'(i), 2'b01});
      chk("route", {1'b1, i[0], i[1]}, mgmt_route);
    end
    // Strap low keeps the clock off pair 2; enable low routes nothing
    @(posedge clk);
    {debug_port_strap, mgmt_clock_enable} <= 2'b01;
    repeat (3) @(posedge clk);
    #1 chk("route", 3'b110, mgmt_route);
    @(posedge clk);
    {debug_port_strap, mgmt_clock_enable} <= 2'b10;
    #1 chk("route", 3'b000, mgmt_route);
    rdc(8'h0B, 8'h0F);
    @(posedge clk);
    {gen2_compliant_pin, cpu_stop_pin_n} <= 2'b00;
    repeat (3) @(posedge clk);
    rdc(8'h0B, 8'h0D);
    #1 chk("pair2 stop", 1'b1, pair2_stop);
    host.wr(8'h0B, 8'h0C);
    chk("pair2 stop", 1'b0, pair2_stop);
    $display("route and stop test done");
    host.wr(8'h0D, 8'h30);
    chk("b13", 7'b0011101, {usb_drive_mid, bus_clock_drive_mid, main_pll_spread_depth, storage_spread_enable,
      strap_overwrite_allowed, single_ended_drive_mid, soft_bus_clock_stop});
    @(posedge clk);
    latches_open <= 0;
    #1 chk("overwrite", 1'b0, strap_overwrite_allowed);
    host.wr(8'h0D, 8'hCF);
    chk("b13", 7'b1100010, {usb_drive_mid, bus_clock_drive_mid, main_pll_spread_depth, storage_spread_enable,
      strap_overwrite_allowed, single_ended_drive_mid, soft_bus_clock_stop});
    host.wr(8'h0E, 8'hA5);
    host.wr(8'h0F, 8'h85);
    chk("freq", {9'h1A5, 7'h05, 3'h5, 1'b1}, cpu_freq);
    @(posedge clk);
    {freq_select_override, prog_cpu_enable} <= 2'b00;
    @(posedge clk);
    #1 chk("freq", {9'h1A5, 7'h05, 3'h2, 1'b0}, cpu_freq);
    $display("control and frequency test done");
    stop_test;
  end
endmodule : ccr_regs_tb
